// ===== host_memory_decoder_defines.vh
// Register offsets, field positions, reset values, route codes and address widths of the decoder
`ifndef HOST_MEMORY_DECODER_DEFINES_VH
`define HOST_MEMORY_DECODER_DEFINES_VH

`define REG_ATTR_EXPANSION 4'h0
`define REG_ATTR_FIRMWARE 4'h1
`define REG_DRAM_HOLE_CONTROL 4'h2
`define REG_MGMT_MEMORY_CONTROL 4'h3
`define REG_ROUTE_STATUS 4'h4
`define REG_DROP_COUNT 4'h5
`define REG_ZERO_READ_COUNT 4'h6

`define ATTR_RESET 26'h0000000
`define HOLE_BIT 0
`define HOLE_RESET 1'b0

`define MMC_BASE_LSB 0
`define MMC_BASE_MSB 2
`define MMC_ENABLE_BIT 3
`define MMC_LOCK_BIT 4
`define MMC_CLOSE_BIT 5
`define MMC_OPEN_BIT 6
`define MMC_BASE_RESET 3'h2
`define MMC_BASE_GRAPHICS 3'h2

`define ROUTE_DRAM 2'h0
`define ROUTE_PCI 2'h1
`define ROUTE_LOCAL 2'h2
`define ROUTE_EXTENDED 2'h3

`define MEM_ADDR_WIDTH 36
`define IO_ADDR_WIDTH 16
`define COUNT_MAX 16'hffff

`endif

// ===== lower_map_route.v
// Routing of host memory cycles inside the lowest megabyte
`include "host_memory_decoder_defines.vh"

module lower_map_route (
  input wire [19:0] addr_in,
  input wire write_in,
  input wire hole_in,
  input wire [25:0] attr_in,
  input wire mgmt_dram_in,
  output reg to_dram_out
);

  // Segment 0..7 expansion, 8..11 extended firmware, 12 system firmware
  function [3:0] seg_index;
    input [19:0] a;
    begin
      if (a[17:16] == 2'h3) begin
        seg_index = 4'hc;
      end else if (!a[17]) begin
        seg_index = {1'b0, a[16:14]};
      end else begin
        seg_index = {2'h2, a[15:14]};
      end
    end
  endfunction

  reg [25:0] shifted;

  always @* begin
    shifted = attr_in >> {seg_index(addr_in), 1'b0};
    if (!addr_in[19]) begin
      to_dram_out = 1'b1;
    end else if (addr_in[19:17] == 3'h4) begin
      to_dram_out = !hole_in;
    end else if (addr_in[19:17] == 3'h5) begin
      to_dram_out = mgmt_dram_in;
    end else begin
      // Disabled DRAM is never moved elsewhere, the cycle just goes out
      to_dram_out = write_in ? shifted[1] : shifted[0];
    end
  end

endmodule

// ===== pci_claim_decode.v
// Decides whether a PCI or ISA master memory cycle is claimed for main DRAM
`include "host_memory_decoder_defines.vh"

module pci_claim_decode (
  input wire valid_in,
  input wire [31:0] addr_in,
  input wire hole_in,
  output reg claim_out
);

  always @* begin
    claim_out = 1'b0;
    if (valid_in && addr_in[31:20] == 12'h000) begin
      if (!addr_in[19]) begin
        claim_out = 1'b1;
      end else if (addr_in[19:17] == 3'h4) begin
        claim_out = !hole_in;
      end else begin
        // Graphics, management and shadowed segments stay with their owners
        claim_out = 1'b0;
      end
    end
  end

endmodule

// ===== host_memory_address_decoder.v
// Host memory and I/O address decoder with attribute, hole and management control
`include "host_memory_decoder_defines.vh"

module host_memory_address_decoder (
  input wire clock_in,
  input wire reset_n_in,
  input wire hreq_valid_in,
  input wire [35:0] hreq_addr_in,
  input wire hreq_write_in,
  input wire hreq_io_in,
  input wire hreq_mgmt_n_in,
  input wire hreq_code_in,
  input wire pci_req_valid_in,
  input wire [31:0] pci_req_addr_in,
  input wire [3:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg route_valid_out,
  output reg route_dram_out,
  output reg route_pci_out,
  output reg route_local_out,
  output reg route_extended_out,
  output reg route_write_out,
  output reg route_io_out,
  output reg [31:0] route_addr_out,
  output reg local_rdata_valid_out,
  output reg [63:0] local_rdata_out,
  output reg pci_claim_out,
  output reg [15:0] reg_rdata_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  reg [25:0] attr_q;
  reg hole_q;
  reg [2:0] mmc_base_q;
  reg mmc_enable_q;
  reg mmc_lock_q;
  reg mmc_close_q;
  reg mmc_open_q;
  reg [1:0] last_route_q;
  reg [15:0] drop_count_q;
  reg [15:0] zero_read_count_q;

  wire wr_attr_exp = reg_wr_in && reg_addr_in == `REG_ATTR_EXPANSION;
  wire wr_attr_fw = reg_wr_in && reg_addr_in == `REG_ATTR_FIRMWARE;
  wire wr_hole = reg_wr_in && reg_addr_in == `REG_DRAM_HOLE_CONTROL;
  wire wr_mmc = reg_wr_in && reg_addr_in == `REG_MGMT_MEMORY_CONTROL;
  wire wr_drop = reg_wr_in && reg_addr_in == `REG_DROP_COUNT;
  wire wr_zero = reg_wr_in && reg_addr_in == `REG_ZERO_READ_COUNT;

  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      attr_q <= `ATTR_RESET;
      hole_q <= `HOLE_RESET;
    end else begin
      if (wr_attr_exp) begin
        attr_q[15:0] <= reg_wdata_in;
      end
      if (wr_attr_fw) begin
        attr_q[25:16] <= reg_wdata_in[9:0];
      end
      if (wr_hole) begin
        hole_q <= reg_wdata_in[`HOLE_BIT];
      end
    end
  end

  // Once locked, only a reset frees base, enable, lock and open again; close stays writable
  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mmc_base_q <= `MMC_BASE_RESET;
      mmc_enable_q <= 1'b0;
      mmc_lock_q <= 1'b0;
      mmc_close_q <= 1'b0;
      mmc_open_q <= 1'b0;
    end else if (wr_mmc) begin
      mmc_close_q <= reg_wdata_in[`MMC_CLOSE_BIT];
      if (!mmc_lock_q) begin
        mmc_base_q <= reg_wdata_in[`MMC_BASE_MSB:`MMC_BASE_LSB];
        mmc_enable_q <= reg_wdata_in[`MMC_ENABLE_BIT];
        mmc_lock_q <= reg_wdata_in[`MMC_LOCK_BIT];
        mmc_open_q <= reg_wdata_in[`MMC_OPEN_BIT] && !reg_wdata_in[`MMC_LOCK_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host cycle decode, purely combinational on current settings

  wire above_4g = |hreq_addr_in[35:32];
  wire in_low_mb = hreq_addr_in[31:20] == 12'h000;
  wire mgmt_active = !hreq_mgmt_n_in;
  wire lower_to_dram;
  reg mgmt_dram;
  reg [1:0] route_d;

  // Open with close set is undefined; close applies in management mode and open outside it
  always @* begin
    mgmt_dram = 1'b0;
    if (mmc_enable_q && mmc_base_q == `MMC_BASE_GRAPHICS) begin
      if (mgmt_active) begin
        mgmt_dram = hreq_code_in || !mmc_close_q;
      end else begin
        mgmt_dram = mmc_open_q && !mmc_lock_q;
      end
    end
  end

  lower_map_route u_lower_map_route (
    .addr_in(hreq_addr_in[19:0]),
    .write_in(hreq_write_in),
    .hole_in(hole_q),
    .attr_in(attr_q),
    .mgmt_dram_in(mgmt_dram),
    .to_dram_out(lower_to_dram)
  );

  always @* begin
    if (hreq_io_in) begin
      route_d = `ROUTE_PCI;
    end else if (above_4g) begin
      route_d = `ROUTE_LOCAL;
    end else if (in_low_mb) begin
      route_d = lower_to_dram ? `ROUTE_DRAM : `ROUTE_PCI;
    end else begin
      route_d = `ROUTE_EXTENDED;
    end
  end

  // I/O addresses wrap at 64 Kbyte; memory keeps its 32-bit address
  wire [31:0] addr_d = hreq_io_in ? {16'h0000, hreq_addr_in[15:0]} : hreq_addr_in[31:0];
  wire local_read = hreq_valid_in && route_d == `ROUTE_LOCAL && !hreq_write_in;
  wire local_write = hreq_valid_in && route_d == `ROUTE_LOCAL && hreq_write_in;

  ////////////////////////////////////////////////////////////////////////////
  // Registered routing outputs, one cycle after the request

  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      route_valid_out <= 1'b0;
      route_dram_out <= 1'b0;
      route_pci_out <= 1'b0;
      route_local_out <= 1'b0;
      route_extended_out <= 1'b0;
      route_write_out <= 1'b0;
      route_io_out <= 1'b0;
      route_addr_out <= 32'h00000000;
      local_rdata_valid_out <= 1'b0;
      local_rdata_out <= 64'h0000000000000000;
      last_route_q <= `ROUTE_DRAM;
    end else begin
      route_valid_out <= hreq_valid_in;
      route_dram_out <= hreq_valid_in && route_d == `ROUTE_DRAM;
      route_pci_out <= hreq_valid_in && route_d == `ROUTE_PCI;
      route_local_out <= hreq_valid_in && route_d == `ROUTE_LOCAL;
      route_extended_out <= hreq_valid_in && route_d == `ROUTE_EXTENDED;
      route_write_out <= hreq_valid_in && hreq_write_in;
      route_io_out <= hreq_valid_in && hreq_io_in;
      route_addr_out <= hreq_valid_in ? addr_d : 32'h00000000;
      // Local reads finish here with zero data; local writes are just dropped
      local_rdata_valid_out <= local_read;
      local_rdata_out <= 64'h0000000000000000;
      if (hreq_valid_in) begin
        last_route_q <= route_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counters of locally terminated cycles; an event with a clear in the same cycle loads one

  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      drop_count_q <= 16'h0000;
      zero_read_count_q <= 16'h0000;
    end else begin
      if (local_write) begin
        if (wr_drop) begin
          drop_count_q <= 16'h0001;
        end else if (drop_count_q != `COUNT_MAX) begin
          drop_count_q <= drop_count_q + 16'h0001;
        end
      end else if (wr_drop) begin
        drop_count_q <= 16'h0000;
      end
      if (local_read) begin
        if (wr_zero) begin
          zero_read_count_q <= 16'h0001;
        end else if (zero_read_count_q != `COUNT_MAX) begin
          zero_read_count_q <= zero_read_count_q + 16'h0001;
        end
      end else if (wr_zero) begin
        zero_read_count_q <= 16'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PCI master claim

  wire pci_claim_d;

  pci_claim_decode u_pci_claim_decode (
    .valid_in(pci_req_valid_in),
    .addr_in(pci_req_addr_in),
    .hole_in(hole_q),
    .claim_out(pci_claim_d)
  );

  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pci_claim_out <= 1'b0;
    end else begin
      pci_claim_out <= pci_claim_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port; unmapped offsets read zero

  reg [15:0] rdata_d;

  always @* begin
    case (reg_addr_in)
      `REG_ATTR_EXPANSION: begin
        rdata_d = attr_q[15:0];
      end
      `REG_ATTR_FIRMWARE: begin
        rdata_d = {6'h00, attr_q[25:16]};
      end
      `REG_DRAM_HOLE_CONTROL: begin
        rdata_d = {15'h0000, hole_q};
      end
      `REG_MGMT_MEMORY_CONTROL: begin
        rdata_d = {9'h000, mmc_open_q, mmc_close_q, mmc_lock_q, mmc_enable_q, mmc_base_q};
      end
      `REG_ROUTE_STATUS: begin
        rdata_d = {14'h0000, last_route_q};
      end
      `REG_DROP_COUNT: begin
        rdata_d = drop_count_q;
      end
      `REG_ZERO_READ_COUNT: begin
        rdata_d = zero_read_count_q;
      end
      default: begin
        rdata_d = 16'h0000;
      end
    endcase
  end

  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_d;
    end else begin
      reg_rdata_out <= 16'h0000;
    end
  end

endmodule

// ===== host_memory_decoder_monitor.sv
// Checker of the decoder's routing, local completion and claim outputs
module decoder_monitor (
  input wire clock_in,
  input wire reset_n_in,
  input wire hreq_valid_in,
  input wire [35:0] hreq_addr_in,
  input wire hreq_write_in,
  input wire hreq_io_in,
  input wire pci_req_valid_in,
  input wire [31:0] pci_req_addr_in,
  input wire route_valid_out,
  input wire route_dram_out,
  input wire route_pci_out,
  input wire route_local_out,
  input wire route_extended_out,
  input wire route_write_out,
  input wire route_io_out,
  input wire local_rdata_valid_out,
  input wire [63:0] local_rdata_out,
  input wire pci_claim_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  wire mem_req = hreq_valid_in && !hreq_io_in;
  wire above = hreq_addr_in[35:32] != 4'h0;
  ////////////////////////////////////////////////////////////////////////////
  a_one_target: assert property (route_valid_out |->
    $onehot({route_dram_out, route_pci_out, route_local_out, route_extended_out}))
    else $error("route targets not one-hot");
  a_idle_quiet: assert property (!hreq_valid_in |=> !route_valid_out && !local_rdata_valid_out)
    else $error("route without request");
  a_low_dram: assert property (mem_req && hreq_addr_in < 36'h80000 |=> route_dram_out)
    else $error("low area not sent to dram");
  a_above_local: assert property (mem_req && above |=> route_local_out && !route_pci_out)
    else $error("above range not claimed locally");
  a_local_zero: assert property (mem_req && above && !hreq_write_in |=>
    local_rdata_valid_out && local_rdata_out == 64'h0)
    else $error("above range read not zero");
  a_io_pci: assert property (hreq_valid_in && hreq_io_in |=> route_pci_out && route_io_out)
    else $error("io cycle not sent to pci");
  a_write_copy: assert property (hreq_valid_in |=> route_write_out == $past(hreq_write_in))
    else $error("write qualifier lost");
  a_claim_high: assert property (pci_req_valid_in && pci_req_addr_in >= 32'ha0000 |=>
    !pci_claim_out)
    else $error("claim of non dram area");
  a_claim_low: assert property (pci_req_valid_in && pci_req_addr_in < 32'h80000 |=>
    pci_claim_out)
    else $error("low area not claimed");
endmodule

bind host_memory_address_decoder decoder_monitor u_mon (.*);

// ===== far_side_model.sv
// Far side sink that tallies cycles handed to the local target
module far_side_model (
  input wire clock_in,
  input wire reset_n_in,
  input wire dram_in,
  input wire pci_in,
  input wire local_in,
  output reg [15:0] local_count_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Local completions never reach dram or pci; only they are tallied here
  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      local_count_out <= 16'h0;
    end else if (local_in && !dram_in && !pci_in) begin
      local_count_out <= local_count_out + 16'h1;
    end
  end
endmodule

// ===== testbench.sv
// Self-checking bench of the host memory address decoder
`include "host_memory_decoder_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  reg clock_in = 0, reset_n_in = 0, hreq_valid_in = 0, hreq_write_in = 0, hreq_io_in = 0;
  reg hreq_mgmt_n_in = 1, hreq_code_in = 0, pci_req_valid_in = 0, reg_wr_in = 0, reg_rd_in = 0;
  reg [35:0] hreq_addr_in = 0;
  reg [31:0] pci_req_addr_in = 0, seed = 32'hf6353e94, a;
  reg [3:0] reg_addr_in = 0;
  reg [15:0] reg_wdata_in = 0, ex = 0;
  reg [9:0] fw = 0;
  reg hole = 0, mg_dram = 0;
  wire route_valid_out, route_dram_out, route_pci_out, route_local_out, route_extended_out;
  wire route_write_out, route_io_out, local_rdata_valid_out, pci_claim_out;
  wire [31:0] route_addr_out;
  wire [63:0] local_rdata_out;
  wire [15:0] reg_rdata_out, local_count;
  integer miscompares = 0, checks = 0, i;
  reg [35:0] corner [0:7] = '{36'h7ffff, 36'h80000, 36'hf0000, 36'ha0000,
    36'hbffff, 36'hc0000, 36'hc3fff, 36'hc4000};
  host_memory_address_decoder u_dut (.*);
  far_side_model u_far (.clock_in(clock_in), .reset_n_in(reset_n_in), .dram_in(route_dram_out),
    .pci_in(route_pci_out), .local_in(route_local_out), .local_count_out(local_count));
  always #50 clock_in = ~clock_in;
  ////////////////////////////////////////////////////////////////////////////
  function [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    xs = seed;
  endfunction
  // One-hot {extended, local, pci, dram}
  function [3:0] expect_route(input [35:0] ad, input w, input io);
    integer s;
    reg [25:0] m;
    m = {fw, ex};
    s = ad[19:14] - 48;
    if (s > 12) s = 12;
    if (io) expect_route = 4'b0010;
    else if (ad[35:32] != 0) expect_route = 4'b0100;
    else if (ad[31:20] != 0) expect_route = 4'b1000;
    else if (ad < 36'h80000) expect_route = 4'b0001;
    else if (ad < 36'ha0000) expect_route = hole ? 4'b0010 : 4'b0001;
    else if (ad < 36'hc0000) expect_route = mg_dram ? 4'b0001 : 4'b0010;
    else expect_route = m[s * 2 + w] ? 4'b0001 : 4'b0010;
  endfunction
  task chk(input [63:0] got, input [63:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task reg_write(input [3:0] ad, input [15:0] d);
    @(posedge clock_in);
    {reg_wr_in, reg_addr_in, reg_wdata_in} <= {1'b1, ad, d};
    @(posedge clock_in);
    reg_wr_in <= 0;
  endtask
  task reg_check(input [3:0] ad, input [15:0] e);
    @(posedge clock_in);
    {reg_rd_in, reg_addr_in} <= {1'b1, ad};
    @(posedge clock_in);
    reg_rd_in <= 0;
    #1 chk(reg_rdata_out, e);
  endtask
  task set_map(input [15:0] e, input [9:0] f, input h);
    reg_write(`REG_ATTR_EXPANSION, e);
    reg_write(`REG_ATTR_FIRMWARE, {6'h0, f});
    reg_write(`REG_DRAM_HOLE_CONTROL, {15'h0, h});
    {ex, fw, hole} = {e, f, h};
  endtask
  task host(input [35:0] ad, input w, input io);
    @(posedge clock_in);
    {hreq_valid_in, hreq_addr_in, hreq_write_in, hreq_io_in} <= {1'b1, ad, w, io};
    @(posedge clock_in);
    hreq_valid_in <= 0;
    #1 chk({route_valid_out, route_extended_out, route_local_out, route_pci_out,
      route_dram_out}, {1'b1, expect_route(ad, w, io)});
    chk(route_addr_out, io ? {16'h0000, ad[15:0]} : ad[31:0]);
  endtask
  task pci_req(input [31:0] ad, input e);
    @(posedge clock_in);
    {pci_req_valid_in, pci_req_addr_in} <= {1'b1, ad};
    @(posedge clock_in);
    pci_req_valid_in <= 0;
    #1 chk(pci_claim_out, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clock_in);
    reset_n_in <= 1;
    for (i = 0; i < 8; i = i + 1) reg_check(i, i == 3 ? 16'h0002 : 16'h0000);
    host(36'hf0000, 0, 0);
    host(36'h100000000, 0, 0);
    host(36'hfffffffff, 1, 0);
    host(36'h100000000, 1, 0);
    reg_check(`REG_DROP_COUNT, 16'h0002);
    reg_check(`REG_ZERO_READ_COUNT, 16'h0001);
    host(36'h0cf8, 0, 1);
    host(36'h100000, 1, 0);
    // Boundaries of hole, graphics and first attribute segment, read and write
    set_map(16'h0001, 10'h300, 1);
    for (i = 0; i < 16; i = i + 1) host(corner[i / 2], i % 2, 0);
    pci_req(32'h1000, 1);
    pci_req(32'h90000, 0);
    pci_req(32'hc0000, 0);
    reg_write(`REG_MGMT_MEMORY_CONTROL, 16'h000a);
    hreq_mgmt_n_in <= 0;
    mg_dram = 1;
    host(36'ha0000, 1, 0);
    reg_write(`REG_MGMT_MEMORY_CONTROL, 16'h002a);
    mg_dram = 0;
    host(36'hbffff, 0, 0);
    hreq_code_in <= 1;
    mg_dram = 1;
    host(36'hb0000, 0, 0);
    {hreq_mgmt_n_in, hreq_code_in} <= 2'b10;
    mg_dram = 0;
    host(36'ha0000, 0, 0);
    // Open outside management mode, then lock, which forces open off for good
    reg_write(`REG_MGMT_MEMORY_CONTROL, 16'h004a);
    mg_dram = 1;
    host(36'ha0000, 0, 0);
    reg_write(`REG_MGMT_MEMORY_CONTROL, 16'h005a);
    mg_dram = 0;
    host(36'ha0000, 0, 0);
    reg_check(`REG_MGMT_MEMORY_CONTROL, 16'h001a);
    // Random traffic; a fresh map is applied just before some requests
    for (i = 0; i < 64; i = i + 1) begin
      if (i % 8 == 0) set_map(xs(), xs(), seed[3]);
      a = xs();
      host({16'h0, a[20] ? {2'b11, a[17:0]} : a[19:0]}, a[31], 0);
    end
    chk(local_count, 16'h0003);
    report_and_stop;
  end
  initial begin
    #1000000;
    miscompares = miscompares + 1;
    report_and_stop;
  end
endmodule
